// *** rtl/current_input_data_status_encoder.sv ***
// four-channel current input encoder: scaling, thresholds, status words
// Overview of operation
// - data word of channel n sits in slot 2n (first, third, fifth, seventh)
// - signed data clamps to -767..32767, unsigned to 0..65535
// - 0-20 mA signed never goes negative, bit 15 stays zero
// - count zero at range bottom; 20 mA gives 32000 signed, 64000 unsigned
// - over-current error at count 32767 signed or 65534 unsigned
// - over-current warning at count 32001 signed or 64001 unsigned
// - under-current error at -767 (4-20 signed) or 0 (0-20); none 4-20 unsigned
// - under-current warning at -1 (4-20 signed), 767 or 1535 in 0-20
// - every threshold flag except open wire comes from comparing counts; open wire compares the current
// - 4-20 range count is (current minus 4 mA) times 2000 or 4000
// - 0-20 range count is current times 1600 or 3200
// - status word of channel n sits in slot 2n+1 after its data
// - global flag is OR of supply, over-current error, open wire, link error
// - bit 1 follows out-of-range field sensor supply; feeds the global flag
// - bit 2 over-current warning, no global flag
// - bit 3 over-current error, sets global flag
// - bit 4 under-current warning, no global flag
// - bit 5 under-current error, no global flag
// - bit 6 open wire, 4-20 range only, below 1 mA; sets global flag
// - bit 7 internal link fault; sets global flag
// - shared supply fault reported within 15 ms, local fault at once
// - disabled channel returns all-zero data and status
// - per-channel averaging over 1 to 80 samples, default 1
`timescale 1ns/1ps
module current_input_data_status_encoder
	import current_input_pkg::*;
#(
	parameter int supply_delay = current_input_pkg::supply_delay_cycles
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [current_input_pkg::num_channels-1:0] sample_valid,
	input wire logic [current_input_pkg::num_channels*24-1:0] sample_ua,
	input wire logic [current_input_pkg::num_channels-1:0] range_0_20,
	input wire logic [current_input_pkg::num_channels-1:0] format_unsigned,
	input wire logic [current_input_pkg::num_channels-1:0] channel_enable,
	input wire logic [current_input_pkg::num_channels*7-1:0] average_count,
	input wire logic shared_supply_fault,
	input wire logic local_supply_fault,
	input wire logic internal_link_error,
	input wire logic [2:0] slot_select,
	output logic [15:0] slot_word,
	output logic [current_input_pkg::num_channels*16-1:0] channel_current_word,
	output logic [current_input_pkg::num_channels*8-1:0] channel_status_word
);
	import current_input_pkg::*;

	if (supply_delay < 1) begin : g_bad_supply_delay
		$error("supply_delay must be at least one cycle");
	end

	// shared supply fault must persist for the delay before it is reported
	logic [31:0] supply_count;
	logic [31:0] next_supply_count;
	logic supply_fault;
	logic next_supply_fault;

	always_comb begin
		next_supply_count = count_zero_32();
		if (shared_supply_fault && supply_count < 32'(supply_delay)) begin
			next_supply_count = supply_count + 32'h0000_0001;
		end else if (shared_supply_fault) begin
			next_supply_count = supply_count;
		end
		// local fault bypasses the delay
		next_supply_fault = local_supply_fault
			|| (shared_supply_fault && supply_count >= 32'(supply_delay) - 32'h0000_0001);
	end

	function automatic logic [31:0] count_zero_32();
		return 32'h0000_0000;
	endfunction : count_zero_32

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			supply_count <= 32'h0000_0000;
			supply_fault <= 1'b0;
		end else begin
			supply_count <= next_supply_count;
			supply_fault <= next_supply_fault;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < num_channels; ch++) begin : g_chan
			logic [31:0] acc;
			logic [31:0] next_acc;
			logic [6:0] n;
			logic [6:0] next_n;
			logic [23:0] avg_ua;
			logic [23:0] next_avg_ua;
			logic avg_done;
			logic next_avg_done;
			logic [15:0] data_word;
			logic [15:0] next_data_word;
			logic [7:0] status_word;
			logic [7:0] next_status_word;
			logic [23:0] in_ua;
			logic [6:0] target;

			assign in_ua = sample_ua[ch*24 +: 24];
			// out-of-range averaging settings fall back to no averaging
			assign target = (average_count[ch*7 +: 7] == 7'h00
				|| average_count[ch*7 +: 7] > 7'(avg_max))
				? avg_default : average_count[ch*7 +: 7];

			always_comb begin
				next_acc = acc;
				next_n = n;
				next_avg_ua = avg_ua;
				next_avg_done = 1'b0;
				if (sample_valid[ch]) begin
					if (n + 7'h01 >= target) begin
						next_avg_ua = 24'((acc + 32'(in_ua)) / 32'(target));
						next_avg_done = 1'b1;
						next_acc = 32'h0000_0000;
						next_n = 7'h00;
					end else begin
						next_acc = acc + 32'(in_ua);
						next_n = n + 7'h01;
					end
				end
			end

			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					acc <= 32'h0000_0000;
					n <= 7'h00;
					avg_ua <= 24'h00_0000;
					avg_done <= 1'b0;
				end else begin
					acc <= next_acc;
					n <= next_n;
					avg_ua <= next_avg_ua;
					avg_done <= next_avg_done;
				end
			end

			// scaling and thresholds, decisions on counts except open wire, which compares the current
			always_comb begin
				logic signed [47:0] scaled;
				logic signed [47:0] cur;
				logic signed [47:0] lo;
				logic signed [47:0] hi;
				logic [15:0] cnt;
				logic uns;
				logic r020;
				logic over_warn;
				logic over_err;
				logic under_warn;
				logic under_err;
				logic ow;
				scaled = '0;
				lo = '0;
				hi = '0;
				cnt = 16'h0000;
				over_warn = 1'b0;
				over_err = 1'b0;
				under_warn = 1'b0;
				under_err = 1'b0;
				ow = 1'b0;
				uns = format_unsigned[ch];
				r020 = range_0_20[ch];
				cur = 48'(avg_ua);
				if (r020) begin
					scaled = cur * (uns ? 48'(gain_0_20_unsigned) : 48'(gain_0_20_signed));
					lo = '0;
				end else begin
					scaled = (cur - $signed(48'(offset_4ma_ua)))
						* (uns ? 48'(gain_4_20_unsigned) : 48'(gain_4_20_signed));
					lo = uns ? 48'sd0 : 48'(signed'(signed_min));
				end
				// signed divide: currents below 4 mA must give negative counts
				scaled = scaled / $signed(48'(ua_per_ma));
				hi = uns ? 48'(unsigned_max) : 48'(signed_max);
				if (scaled < lo) begin
					scaled = lo;
				end else if (scaled > hi) begin
					scaled = hi;
				end
				cnt = scaled[15:0];
				if (uns) begin
					over_err = cnt >= unsigned_overcurrent_error;
					over_warn = cnt >= unsigned_overcurrent_warning;
					under_err = r020 && cnt == count_zero;
					under_warn = r020 && cnt <= unsigned_undercurrent_warning_0_20;
				end else begin
					over_err = $signed(cnt) >= $signed(signed_overcurrent_error);
					over_warn = $signed(cnt) >= $signed(signed_overcurrent_warning);
					under_err = r020 ? cnt == count_zero
						: $signed(cnt) <= $signed(signed_undercurrent_error_4_20);
					under_warn = r020
						? $signed(cnt) <= $signed(signed_undercurrent_warning_0_20)
						: $signed(cnt) <= $signed(signed_undercurrent_warning_4_20);
				end
				ow = !r020 && avg_ua < open_wire_ua;
				next_data_word = data_word;
				next_status_word = status_word;
				if (!channel_enable[ch]) begin
					next_data_word = 16'h0000;
					next_status_word = 8'h00;
				end else if (avg_done) begin
					next_data_word = cnt;
					next_status_word[bit_supply] = supply_fault;
					next_status_word[bit_overcurrent_warning] = over_warn;
					next_status_word[bit_overcurrent_error] = over_err;
					next_status_word[bit_undercurrent_warning] = under_warn;
					next_status_word[bit_undercurrent_error] = under_err;
					next_status_word[bit_open_wire] = ow;
					next_status_word[bit_link] = internal_link_error;
					next_status_word[bit_global] = supply_fault || over_err || ow
						|| internal_link_error;
				end else begin
					// supply and link faults show without waiting for a sample
					next_status_word[bit_supply] = supply_fault;
					next_status_word[bit_link] = internal_link_error;
					next_status_word[bit_global] = supply_fault
						|| status_word[bit_overcurrent_error]
						|| status_word[bit_open_wire] || internal_link_error;
				end
			end

			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					data_word <= 16'h0000;
					status_word <= 8'h00;
				end else begin
					data_word <= next_data_word;
					status_word <= next_status_word;
				end
			end

			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					channel_current_word[ch*16 +: 16] <= 16'h0000;
					channel_status_word[ch*8 +: 8] <= 8'h00;
				end else begin
					channel_current_word[ch*16 +: 16] <= next_data_word;
					channel_status_word[ch*8 +: 8] <= next_status_word;
				end
			end

			a_global_flag: assert property (@(posedge clk) disable iff (rst)
				status_word[bit_global] == (status_word[bit_supply]
				|| status_word[bit_overcurrent_error]
				|| status_word[bit_open_wire] || status_word[bit_link]))
				else $error("global flag mismatch");
			a_disabled_zero: assert property (@(posedge clk) disable iff (rst)
				!channel_enable[ch] |=> data_word == 16'h0000 && status_word == 8'h00)
				else $error("disabled channel not zero");
			a_signed_range: assert property (@(posedge clk) disable iff (rst)
				channel_enable[ch] && !format_unsigned[ch] && $past(!format_unsigned[ch])
				&& $past(avg_done) |-> $signed(data_word) >= $signed(signed_min))
				else $error("signed data below range");
			a_zero_range_positive: assert property (@(posedge clk) disable iff (rst)
				$past(avg_done) && $past(range_0_20[ch]) && $past(!format_unsigned[ch])
				&& $past(channel_enable[ch]) |-> !data_word[15])
				else $error("negative count in 0-20 range");
			a_over_error_level: assert property (@(posedge clk) disable iff (rst)
				$past(avg_done) && $past(channel_enable[ch]) && $past(format_unsigned[ch])
				|-> status_word[bit_overcurrent_error]
				== (data_word >= unsigned_overcurrent_error))
				else $error("unsigned over-current error mismatch");
			a_over_warning_level: assert property (@(posedge clk) disable iff (rst)
				$past(avg_done) && $past(channel_enable[ch]) && $past(!format_unsigned[ch])
				|-> status_word[bit_overcurrent_warning]
				== ($signed(data_word) >= $signed(signed_overcurrent_warning)))
				else $error("signed over-current warning mismatch");
			a_open_wire_range: assert property (@(posedge clk) disable iff (rst)
				$past(avg_done) && $past(range_0_20[ch]) |-> !status_word[bit_open_wire])
				else $error("open wire flagged in 0-20 range");
			a_under_error_unsigned: assert property (@(posedge clk) disable iff (rst)
				$past(avg_done) && $past(!range_0_20[ch]) && $past(format_unsigned[ch])
				|-> !status_word[bit_undercurrent_error])
				else $error("unsigned 4-20 under-current error");
			a_under_warning_unsigned: assert property (@(posedge clk) disable iff (rst)
				$past(avg_done) && $past(!range_0_20[ch]) && $past(format_unsigned[ch])
				|-> !status_word[bit_undercurrent_warning])
				else $error("unsigned 4-20 under-current warning");
			a_supply_bit_follows: assert property (@(posedge clk) disable iff (rst)
				$past(channel_enable[ch]) |-> status_word[bit_supply] == $past(supply_fault))
				else $error("supply bit does not follow supply fault");
		end
	endgenerate

	// slot mux: even slot data, odd slot status
	logic [15:0] next_slot_word;
	always_comb begin
		if (slot_select[0]) begin
			next_slot_word = {8'h00, channel_status_word[slot_select[2:1]*8 +: 8]};
		end else begin
			next_slot_word = channel_current_word[slot_select[2:1]*16 +: 16];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			slot_word <= 16'h0000;
		end else begin
			slot_word <= next_slot_word;
		end
	end

	a_local_fault: assert property (@(posedge clk) disable iff (rst)
		local_supply_fault |=> supply_fault)
		else $error("local fault not immediate");
endmodule : current_input_data_status_encoder

// *** rtl/current_input_pkg.sv ***
// constants for the four-channel current input data and status encoder
package current_input_pkg;
	localparam int num_channels = 4;
	localparam int num_slots = 8;
	localparam int data_width = 16;
	localparam int status_width = 8;
	localparam int sample_width = 24;
	// sample scale: raw input is current in microamps
	localparam logic [23:0] ua_per_ma = 24'h00_03E8;
	localparam logic [23:0] offset_4ma_ua = 24'h00_0FA0;
	localparam logic [23:0] open_wire_ua = 24'h00_03E8;
	// counts per mA
	localparam int gain_4_20_signed = 2000;
	localparam int gain_4_20_unsigned = 4000;
	localparam int gain_0_20_signed = 1600;
	localparam int gain_0_20_unsigned = 3200;
	// signed thresholds (two's complement, 16 bit)
	localparam logic [15:0] signed_min = 16'hFD01;
	localparam logic [15:0] signed_max = 16'h7FFF;
	localparam logic [15:0] signed_overcurrent_error = 16'h7FFF;
	localparam logic [15:0] signed_overcurrent_warning = 16'h7D01;
	localparam logic [15:0] signed_undercurrent_error_4_20 = 16'hFD01;
	localparam logic [15:0] signed_undercurrent_warning_4_20 = 16'hFFFF;
	localparam logic [15:0] signed_undercurrent_warning_0_20 = 16'h02FF;
	// unsigned thresholds
	localparam logic [15:0] unsigned_max = 16'hFFFF;
	localparam logic [15:0] unsigned_overcurrent_error = 16'hFFFE;
	localparam logic [15:0] unsigned_overcurrent_warning = 16'hFA01;
	localparam logic [15:0] unsigned_undercurrent_warning_0_20 = 16'h05FF;
	localparam logic [15:0] count_zero = 16'h0000;
	// status bit positions
	localparam int bit_global = 0;
	localparam int bit_supply = 1;
	localparam int bit_overcurrent_warning = 2;
	localparam int bit_overcurrent_error = 3;
	localparam int bit_undercurrent_warning = 4;
	localparam int bit_undercurrent_error = 5;
	localparam int bit_open_wire = 6;
	localparam int bit_link = 7;
	// averaging limits
	localparam int avg_max = 80;
	localparam logic [6:0] avg_default = 7'h01;
	// shared supply fault debounce
	localparam int supply_delay_ms = 15;
	localparam int clk_mhz = 100;
	localparam int supply_delay_cycles = supply_delay_ms * 1000 * clk_mhz;
endpackage : current_input_pkg

// *** testbench/island_network_head.sv ***
// reader model that fetches the eight process image slots
`timescale 1ns/1ps
module island_network_head (
	input wire logic clk,
	input wire logic [15:0] slot_word,
	input wire logic [31:0] channel_status_word,
	output logic [2:0] slot_select,
	output logic [3:0] suspect
);
	initial slot_select = 3'h0;
	// data of a channel is not trusted while its global flag is up
	always_comb begin
		for (int c = 0; c < 4; c++) suspect[c] = channel_status_word[c*8];
	end
	task automatic read_slot(input logic [2:0] s, output logic [15:0] w);
		@(negedge clk);
		slot_select = s;
		@(negedge clk);
		w = slot_word;
	endtask : read_slot
endmodule : island_network_head

// *** testbench/current_input_data_status_encoder_tb_top.sv ***
// testbench for the four-channel current input encoder
`timescale 1ns/1ps
`define check(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
	$display("ERROR %s expected %h seen %h", what, exp, got); end end
module current_input_data_status_encoder_tb_top;
	logic clk, rst;
	logic [3:0] sample_valid, range_0_20, format_unsigned, channel_enable, suspect;
	logic [95:0] sample_ua;
	logic [27:0] average_count;
	logic shared_supply_fault, local_supply_fault, internal_link_error;
	logic [2:0] slot_select;
	logic [15:0] slot_word;
	logic [63:0] channel_current_word;
	logic [31:0] channel_status_word;
	logic [15:0] ed [4];
	logic [7:0] es [4];
	int errors = 0;
	int cmp_count = 0;
	current_input_data_status_encoder #(.supply_delay(4)) current_input_data_status_encoder_i (
		.clk(clk), .rst(rst), .sample_valid(sample_valid), .sample_ua(sample_ua),
		.range_0_20(range_0_20), .format_unsigned(format_unsigned),
		.channel_enable(channel_enable), .average_count(average_count),
		.shared_supply_fault(shared_supply_fault), .local_supply_fault(local_supply_fault),
		.internal_link_error(internal_link_error), .slot_select(slot_select),
		.slot_word(slot_word), .channel_current_word(channel_current_word),
		.channel_status_word(channel_status_word)
	);
	island_network_head island_network_head_i (
		.clk(clk), .slot_word(slot_word), .channel_status_word(channel_status_word),
		.slot_select(slot_select), .suspect(suspect)
	);
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results
	// same current on all four channels, then let the words settle
	task automatic sample(input logic [23:0] ua);
		@(negedge clk);
		sample_ua = {4{ua}};
		sample_valid = 4'hF;
		@(negedge clk);
		sample_valid = 4'h0;
		repeat (4) @(negedge clk);
	endtask : sample
	task automatic check_all(input string name);
		logic [15:0] w;
		for (int c = 0; c < 4; c++) begin
			island_network_head_i.read_slot(3'(2 * c), w);
			`check("data", ed[c], w)
			`check("data word", ed[c], channel_current_word[c*16+:16])
			island_network_head_i.read_slot(3'(2 * c + 1), w);
			`check("status", {8'h00, es[c]}, w)
			`check("status word", es[c], channel_status_word[c*8+:8])
		end
		$display("test %s done", name);
	endtask : check_all
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial begin
		#100us;
		errors++;
		results();
	end
	// channels: 4-20 signed, 4-20 unsigned, 0-20 signed, 0-20 unsigned
	initial begin
		rst = 1;
		sample_valid = 0;
		sample_ua = 0;
		range_0_20 = 4'b1100;
		format_unsigned = 4'b1010;
		channel_enable = 4'hF;
		average_count = {4{7'h01}};
		shared_supply_fault = 0;
		local_supply_fault = 0;
		internal_link_error = 0;
		repeat (8) @(negedge clk);
		rst = 0;
		ed = '{4{16'h0000}};
		es = '{4{8'h00}};
		check_all("reset");
		sample(24'd20000);
		ed = '{16'h7D00, 16'hFA00, 16'h7D00, 16'hFA00};
		check_all("full scale");
		sample(24'd20001);
		ed = '{16'h7D02, 16'hFA04, 16'h7D01, 16'hFA03};
		es = '{4{8'h04}};
		check_all("over warning");
		sample(24'd21000);
		ed = '{16'h7FFF, 16'hFFFF, 16'h7FFF, 16'hFFFF};
		es = '{4{8'h0D}};
		check_all("over error");
		`check("suspect", 4'hF, suspect)
		sample(24'd3999);
		ed = '{16'hFFFE, 16'h0000, 16'h18FE, 16'h31FC};
		es = '{8'h10, 8'h00, 8'h00, 8'h00};
		check_all("under warning");
		sample(24'd1000);
		ed = '{16'hFD01, 16'h0000, 16'h0640, 16'h0C80};
		es = '{8'h30, 8'h00, 8'h00, 8'h00};
		check_all("wire limit");
		sample(24'd479);
		ed = '{16'hFD01, 16'h0000, 16'h02FE, 16'h05FC};
		es = '{8'h71, 8'h41, 8'h10, 8'h10};
		check_all("open wire");
		sample(24'd0);
		ed[2] = 16'h0000;
		ed[3] = 16'h0000;
		es = '{8'h71, 8'h41, 8'h30, 8'h30};
		check_all("zero");
		sample(24'd20000);
		ed = '{16'h7D00, 16'hFA00, 16'h7D00, 16'hFA00};
		local_supply_fault = 1;
		repeat (2) @(negedge clk);
		es = '{4{8'h03}};
		check_all("local supply");
		local_supply_fault = 0;
		internal_link_error = 1;
		repeat (2) @(negedge clk);
		es = '{4{8'h81}};
		check_all("link error");
		internal_link_error = 0;
		shared_supply_fault = 1;
		repeat (8) @(negedge clk);
		es = '{4{8'h03}};
		check_all("shared supply");
		shared_supply_fault = 0;
		channel_enable = 4'h5;
		repeat (8) @(negedge clk);
		ed[1] = 16'h0000;
		ed[3] = 16'h0000;
		es = '{4{8'h00}};
		check_all("disable");
		channel_enable = 4'hF;
		// ch1 zero and ch3 above 80 must both fall back to single samples
		average_count = {7'h51, 7'h01, 7'h00, 7'h02};
		sample(24'd20000);
		sample(24'd12000);
		ed = '{16'h5DC0, 16'h7D00, 16'h4B00, 16'h9600};
		check_all("average");
		results();
	end
endmodule : current_input_data_status_encoder_tb_top
